// [rtl/fcb_branch_unit.sv]
`timescale 1ns/1ps
module fcb_branch_unit
(
  input  wire logic                         clock_i,
  input  wire logic                         arst_n_i,
  input  wire logic                         ce_i,
  input  wire logic [1:0]                   phase_i,
  input  wire logic                         insn_valid_i,
  input  wire logic [fcb_pkg::WORD_W-1:0]   insn_i,
  input  wire logic [fcb_pkg::PC_W-1:0]     pc_i,
  input  wire logic                         ovf_i,
  input  wire logic                         zero_i,
  output logic                              is_branch_o,
  output logic                              busy_o,
  output logic                              pc_we_o,
  output logic [fcb_pkg::PC_W-1:0]          pc_o,
  output logic                              taken_o,
  output logic                              flags_we_o
);

  fcb_pkg::fcb_state_t             state_reg;
  fcb_pkg::fcb_state_t             state_next;
  logic [fcb_pkg::WORD_W-1:0]      insn_reg;
  logic                            taken_reg;
  logic [fcb_pkg::PC_W-1:0]        pc_reg;
  logic                            pc_we_reg;

  wire logic [7:0]                 opc;
  wire logic                       dec_ovf;
  wire logic                       dec_zer;
  wire logic                       dec_any;
  wire logic                       cond_ok;
  wire logic                       start;
  wire logic                       at_dec;
  wire logic                       at_wr;
  wire logic                       held_ovf;

  fcb_target_if tif ();

  fcb_target_calc u_calc
  (
    .t (tif.calc)
  );

  function automatic logic match_opc(input logic [7:0] o, input logic [7:0] ref_o);
    match_opc = (o == ref_o);
  endfunction

  assign dec_ovf  = match_opc(opc, fcb_pkg::OPC_OVF_CLR);
  assign dec_zer  = match_opc(opc, fcb_pkg::OPC_ZER_CLR);
  assign opc      = insn_i[fcb_pkg::OPC_HI:fcb_pkg::OPC_LO];
  assign dec_any  = dec_ovf | dec_zer;
  assign at_dec   = ce_i && (phase_i == fcb_pkg::PHASE_DEC);
  assign at_wr    = ce_i && (phase_i == fcb_pkg::PHASE_WR);
  assign start    = at_dec && insn_valid_i && dec_any && (state_reg == fcb_pkg::FCB_IDLE);
  // latched word picks the flag, the live insn_i may already hold the next word
  assign held_ovf = match_opc(insn_reg[fcb_pkg::OPC_HI:fcb_pkg::OPC_LO],
                              fcb_pkg::OPC_OVF_CLR);
  assign cond_ok  = held_ovf ? !ovf_i : !zero_i;
  // offset from low byte of latched word
  assign tif.offs = insn_reg[fcb_pkg::OFFS_HI:fcb_pkg::OFFS_LO];
  assign tif.pc   = pc_i;

  // flags are never written by these branches
  assign flags_we_o  = 1'b0;
  assign is_branch_o = insn_valid_i && dec_any;
  assign busy_o      = (state_reg != fcb_pkg::FCB_IDLE);
  assign pc_we_o     = pc_we_reg;
  assign pc_o        = pc_reg;
  assign taken_o     = taken_reg;

  // exec cycle, then a nop cycle when taken
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      fcb_pkg::FCB_IDLE:
        if (start)
          state_next = fcb_pkg::FCB_EXEC;
      fcb_pkg::FCB_EXEC:
        // untaken ends at the close of the first cycle
        if (at_wr)
          state_next = cond_ok ? fcb_pkg::FCB_NOP : fcb_pkg::FCB_IDLE;
      fcb_pkg::FCB_NOP:
        if (at_wr)
          state_next = fcb_pkg::FCB_IDLE;
      default:
        state_next = fcb_pkg::FCB_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= fcb_pkg::FCB_IDLE;
      insn_reg  <= '0;
      taken_reg <= 1'b0;
      pc_reg    <= '0;
      pc_we_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      if (start)
        insn_reg <= insn_i;
      // write pc = incremented pc + 2n in last phase
      pc_we_reg <= (state_reg == fcb_pkg::FCB_EXEC) && at_wr && cond_ok;
      if ((state_reg == fcb_pkg::FCB_EXEC) && at_wr)
      begin
        taken_reg <= cond_ok;
        if (cond_ok)
          pc_reg <= tif.target;
      end
    end
  end

  // no pc write when flag set
  a_no_write_untaken : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (ce_i && state_reg == fcb_pkg::FCB_EXEC && at_wr && !cond_ok) |=> !pc_we_o)
    else $error("pc written on untaken branch");

  a_target_value : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (state_reg == fcb_pkg::FCB_EXEC && at_wr && cond_ok) |=>
      (pc_we_o && pc_o == $past(pc_i) +
       {{(fcb_pkg::PC_W-9){$past(insn_reg[7])}}, $past(insn_reg[7:0]), 1'b0}))
    else $error("branch target wrong");

  a_taken_nop : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (ce_i && state_reg == fcb_pkg::FCB_EXEC && at_wr && cond_ok) |=>
      state_reg == fcb_pkg::FCB_NOP)
    else $error("taken branch skipped nop cycle");

  a_ovf_decode : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (insn_valid_i && insn_i[15:8] == 8'he5) |-> is_branch_o)
    else $error("overflow-clear branch not decoded");

  a_zero_decode : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (insn_valid_i && insn_i[15:8] == 8'he1) |-> is_branch_o)
    else $error("zero-clear branch not decoded");

  a_flags_kept : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    busy_o |-> !flags_we_o)
    else $error("branch wrote flags");

  a_write_source : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    $rose(pc_we_o) |-> $past(state_reg) == fcb_pkg::FCB_EXEC)
    else $error("pc write outside exec cycle");

  a_untaken_idle : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (ce_i && state_reg == fcb_pkg::FCB_EXEC && at_wr && !cond_ok) |=>
      state_reg == fcb_pkg::FCB_IDLE)
    else $error("untaken branch took extra cycle");

  // exec cycle lasts until its write phase
  a_exec_hold : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (ce_i && state_reg == fcb_pkg::FCB_EXEC && !at_wr) |=>
      state_reg == fcb_pkg::FCB_EXEC)
    else $error("exec cycle ended early");

  // nop cycle runs all four phases
  a_nop_hold : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (ce_i && state_reg == fcb_pkg::FCB_NOP && !at_wr) |=>
      state_reg == fcb_pkg::FCB_NOP)
    else $error("nop cycle ended early");

  a_nop_quiet : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (ce_i && state_reg == fcb_pkg::FCB_NOP) |=> !pc_we_o)
    else $error("pc written in nop cycle");

  // end of nop cycle frees the unit
  a_nop_done : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (state_reg == fcb_pkg::FCB_NOP && at_wr) |=> !busy_o)
    else $error("unit still busy after nop cycle");

  // decoded word is held for the whole branch
  a_word_latched : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    start |=> (state_reg == fcb_pkg::FCB_EXEC && insn_reg == $past(insn_i)))
    else $error("branch word not latched at decode");

  // write strobe lasts one enabled edge
  a_we_pulse : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (ce_i && pc_we_o) |=> !pc_we_o)
    else $error("pc write strobe held too long");

  // untaken branch keeps the old target
  a_untaken_pc_kept : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (state_reg == fcb_pkg::FCB_EXEC && at_wr && !cond_ok) |=> $stable(pc_o))
    else $error("pc target changed on untaken branch");

  // set overflow flag blocks the branch
  a_ovf_blocks : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (state_reg == fcb_pkg::FCB_EXEC && at_wr && held_ovf && ovf_i) |=> !taken_o)
    else $error("branch taken with overflow set");

  // set zero flag blocks the branch
  a_zero_blocks : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (state_reg == fcb_pkg::FCB_EXEC && at_wr && !held_ovf && zero_i) |=> !taken_o)
    else $error("branch taken with zero set");

  a_other_ignored : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (opc != fcb_pkg::OPC_OVF_CLR && opc != fcb_pkg::OPC_ZER_CLR) |-> !is_branch_o)
    else $error("unknown opcode decoded as branch");

  // a stalled core must see the same state when the enable returns
  a_ce_freeze : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !ce_i |=> ($stable(state_reg) && $stable(pc_o) && $stable(pc_we_o) && $stable(taken_o)))
    else $error("state moved while clock enable low");

endmodule

// [rtl/fcb_pkg.sv]
package fcb_pkg;

  localparam int          WORD_W      = 16;
  localparam int          PC_W        = 21;
  localparam int          OFFS_W      = 8;
  localparam logic [7:0]  OPC_OVF_CLR = 8'he5;
  localparam logic [7:0]  OPC_ZER_CLR = 8'he1;
  localparam int          OPC_HI      = 15;
  localparam int          OPC_LO      = 8;
  localparam int          OFFS_HI     = 7;
  localparam int          OFFS_LO     = 0;
  localparam logic [1:0]  PHASE_DEC   = 2'h0;
  localparam logic [1:0]  PHASE_RD    = 2'h1;
  localparam logic [1:0]  PHASE_PROC  = 2'h2;
  localparam logic [1:0]  PHASE_WR    = 2'h3;
  localparam int          TAKEN_CYC   = 2;
  localparam int          SKIP_CYC    = 1;

  typedef enum logic [1:0]
  {
    FCB_IDLE  = 2'b00,
    FCB_EXEC  = 2'b01,
    FCB_NOP   = 2'b10
  } fcb_state_t;

endpackage

// [rtl/fcb_target_if.sv]
`timescale 1ns/1ps
interface fcb_target_if;
  logic [fcb_pkg::PC_W-1:0]   pc;
  logic [fcb_pkg::OFFS_W-1:0] offs;
  logic [fcb_pkg::PC_W-1:0]   target;

  modport core
  (
    output pc,
    output offs,
    input  target
  );
  modport calc
  (
    input  pc,
    input  offs,
    output target
  );
endinterface

// [rtl/fcb_target_calc.sv]
`timescale 1ns/1ps
module fcb_target_calc
(
  fcb_target_if.calc t
);
  // sign-extend, double, add; wraps modulo the pc width
  wire logic [fcb_pkg::PC_W-1:0] offs_x2;

  assign offs_x2  = {{(fcb_pkg::PC_W-fcb_pkg::OFFS_W-1){t.offs[fcb_pkg::OFFS_W-1]}}, t.offs, 1'b0};
  assign t.target = t.pc + offs_x2;
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int PW = fcb_pkg::PC_W;
  logic          clock_i      = 1'b0;
  logic          arst_n_i     = 1'b0;
  logic          ce_i         = 1'b0;
  logic [1:0]    phase_i      = 2'h0;
  logic          insn_valid_i = 1'b0;
  logic [15:0]   insn_i       = 16'h0000;
  logic [PW-1:0] pc_i         = '0;
  logic          ovf_i        = 1'b0;
  logic          zero_i       = 1'b0;
  logic          is_branch_o, busy_o, pc_we_o, taken_o, flags_we_o;
  logic [PW-1:0] pc_o;
  int            fail_count   = 0;
  int            checks       = 0;
  int            seed         = 64985;
  logic [PW-1:0] last_pc      = '0;

  always #4 clock_i = ~clock_i;

  fcb_branch_unit fcb_branch_unit_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .phase_i(phase_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i), .pc_i(pc_i),
    .ovf_i(ovf_i), .zero_i(zero_i), .is_branch_o(is_branch_o), .busy_o(busy_o),
    .pc_we_o(pc_we_o), .pc_o(pc_o), .taken_o(taken_o), .flags_we_o(flags_we_o));

  function automatic logic [PW-1:0] tgt(input logic [PW-1:0] pc, input logic [7:0] n);
    // doubled offset, sign extended, wraps with the pc width
    return pc + ({{(PW-8){n[7]}}, n} << 1);
  endfunction

  task automatic check(input string what, input logic [PW-1:0] seen, input logic [PW-1:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // random stalls show that a low enable freezes the sequence
  task automatic step(input logic [1:0] ph);
    @(negedge clock_i);
    if (($random(seed) & 3) == 0)
    begin
      ce_i = 1'b0;
      @(negedge clock_i);
    end
    ce_i = 1'b1;
    phase_i = ph;
  endtask

  task automatic cycle_end(input logic exp_busy);
    step(2'h1);
    check("busy_mid", busy_o, exp_busy);
    step(2'h2);
    step(2'h3);
    @(negedge clock_i);
    ce_i = 1'b0;
  endtask

  task automatic run_op(input logic [7:0] opc, input logic [7:0] n, input logic flag);
    logic [PW-1:0] pc;
    logic          bra;
    logic          tk;
    pc = PW'($random(seed));
    bra = (opc === fcb_pkg::OPC_OVF_CLR) || (opc === fcb_pkg::OPC_ZER_CLR);
    tk = bra && !flag;
    step(2'h0);
    insn_i = {opc, n};
    insn_valid_i = 1'b1;
    pc_i = pc;
    ovf_i = (opc === fcb_pkg::OPC_OVF_CLR) ? flag : 1'($random(seed));
    zero_i = (opc === fcb_pkg::OPC_ZER_CLR) ? flag : 1'($random(seed));
    #1 check("is_branch", is_branch_o, bra);
    cycle_end(bra);
    check("pc_we", pc_we_o, tk);
    check("busy", busy_o, tk);
    check("flags_we", flags_we_o, 1'b0);
    if (bra) check("taken", taken_o, tk);
    if (tk) check("target", pc_o, tgt(pc, n));
    if (tk) last_pc = tgt(pc, n);
    check("pc_kept", pc_o, last_pc);
    if (tk)
    begin
      // a branch offered during the nop cycle must be ignored
      step(2'h0);
      insn_i = {fcb_pkg::OPC_ZER_CLR, n};
      zero_i = 1'b0;
      cycle_end(1'b1);
      check("nop_pc_we", pc_we_o, 1'b0);
      check("nop_busy", busy_o, 1'b0);
      check("nop_target", pc_o, tgt(pc, n));
    end
    insn_valid_i = 1'b0;
  endtask

  initial
  begin
    logic [7:0] opc;
    repeat (2) @(negedge clock_i);
    arst_n_i = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      opc = k ? fcb_pkg::OPC_ZER_CLR : fcb_pkg::OPC_OVF_CLR;
      run_op(opc, 8'h80, 1'b0);
      run_op(opc, 8'h7f, 1'b0);
      run_op(opc, 8'hff, 1'b1);
      run_op(opc, 8'h00, 1'b0);
    end
    run_op(8'he3, 8'h10, 1'b0);
    repeat (200)
    begin
      case ($random(seed) & 3)
        0: opc = fcb_pkg::OPC_OVF_CLR;
        1: opc = fcb_pkg::OPC_ZER_CLR;
        default: opc = 8'($random(seed));
      endcase
      run_op(opc, 8'($random(seed)), 1'($random(seed)));
    end
    complete_run();
  end

  initial
  begin
    repeat (30000) @(posedge clock_i);
    fail_count++;
    complete_run();
  end
endmodule
